// ===== bench/fcs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_core_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic op_start_i,
	input wire logic suspend_i,
	input wire logic resume_i,
	input wire logic [7:0] lat_i,
	input wire logic fail_i,
	output logic done_o,
	output logic fail_o,
	output logic pause_o
);
	logic run;
	logic held;
	logic [7:0] cnt;
	logic [3:0] scnt;
	// Pause comes eight cycles late so the host must poll for it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			run <= 1'b0;
			held <= 1'b0;
			cnt <= 8'h00;
			scnt <= 4'h0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			pause_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			pause_o <= 1'b0;
			if (op_start_i) begin
				run <= 1'b1;
				held <= 1'b0;
				cnt <= lat_i;
				scnt <= 4'h0;
			end else if (resume_i) begin
				held <= 1'b0;
				scnt <= 4'h0;
			end else if (run && suspend_i && !held) begin
				scnt <= scnt + 4'h1;
				if (scnt == 4'h7) begin
					pause_o <= 1'b1;
					held <= 1'b1;
				end
			end else if (run && !held) begin
				cnt <= cnt - 8'h01;
				if (cnt == 8'h00) begin
					run <= 1'b0;
					done_o <= 1'b1;
					fail_o <= fail_i;
				end
			end
		end
	end
endmodule : fcs_core_model
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fcs_pkg::*;
	// Arbitrary identification values
	localparam logic [15:0] MFR = 16'h00a5;
	localparam logic [15:0] DEV = 16'h5a3c;
	localparam logic [31:0] ARR = 32'h1234abcd;
	localparam logic [31:0] QRY = 32'h0000c35a;
	logic clk_i, rst_b, ce_b, oe_b, we_b, word32, vpp_ok, fail, c_done, c_fail, c_pause;
	logic [23:1] addr, wta;
	logic [31:0] wdata, data_o, data_oe, d, last_oe, wval;
	logic [7:0] st, lat;
	logic [15:0] bsv;
	logic apply, start, susp, resm, bufw;
	fcs_op_t kind, last_kind;
	logic [6:0] blk;
	int err_count, checks, n_apply, n_buf, n_res, na;
	fcs_top #(.MFR_ID(MFR), .DEV_ID(DEV)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b), .ce_b_i(ce_b),
		.oe_b_i(oe_b), .we_b_i(we_b), .addr_i(addr), .data_i(wdata), .word32_i(word32),
		.vpp_ok_i(vpp_ok), .array_data_i(ARR), .query_data_i(QRY), .core_done_i(c_done),
		.core_fail_i(c_fail), .core_pause_i(c_pause), .data_o(data_o), .data_oe_o(data_oe),
		.operation_status_o(st), .burst_setup_value_o(bsv), .burst_apply_o(apply),
		.op_start_o(start), .op_kind_o(kind), .block_base_addr_o(blk), .buf_wr_o(bufw),
		.write_target_addr_o(wta), .write_value_o(wval), .suspend_o(susp), .resume_o(resm));
	fcs_core_model u_core (.clk_i(clk_i), .rst_b_i(rst_b), .op_start_i(start), .suspend_i(susp),
		.resume_i(resm), .lat_i(lat), .fail_i(fail), .done_o(c_done), .fail_o(c_fail),
		.pause_o(c_pause));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		n_apply += int'(apply === 1'b1);
		n_buf += int'(bufw === 1'b1);
		n_res += int'(resm === 1'b1);
		if (start === 1'b1) last_kind = kind;
	end
	// ********************************
	// Bus tasks
	// ********************************
	task automatic final_report();
		if (err_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [23:1] ba(input logic [6:0] b);
		return {b, 16'h0000};
	endfunction : ba
	// Write is taken when we_b is seen high again with ce_b still low
	task automatic bus_write(input logic [23:1] a, input logic [7:0] v);
		@(negedge clk_i);
		ce_b = 1'b0;
		we_b = 1'b0;
		addr = a;
		wdata = {24'h000000, v};
		@(negedge clk_i);
		we_b = 1'b1;
		@(negedge clk_i);
		ce_b = 1'b1;
	endtask : bus_write
	task automatic bus_read(input logic [23:1] a, output logic [31:0] v);
		@(negedge clk_i);
		ce_b = 1'b0;
		oe_b = 1'b0;
		addr = a;
		repeat (3) @(negedge clk_i);
		v = data_o;
		last_oe = data_oe;
		ce_b = 1'b1;
		oe_b = 1'b1;
	endtask : bus_read
	task automatic expect_status(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			bus_read(23'h000000, d);
			n++;
		end while (d[7] !== 1'b1 && n < 300);
		if (d[7] !== 1'b1) begin
			err_count++;
			final_report();
		end
		check(d, {24'h000000, e});
	endtask : expect_status
	task automatic clear_status();
		bus_write(23'h000000, 8'h50);
		bus_write(23'h000000, 8'h70);
		expect_status(8'h80); // errors cleared
	endtask : clear_status
	// ********************************
	// Sequence
	// ********************************
	initial begin
		ce_b = 1'b1;
		oe_b = 1'b1;
		we_b = 1'b1;
		addr = '0;
		wdata = '0;
		word32 = 1'b1;
		vpp_ok = 1'b1;
		lat = 8'h10;
		fail = 1'b0;
		rst_b = 1'b0;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_b = 1'b1;
		check({24'h000000, st}, 32'h80); // idle status
		bus_read(23'h000000, d);
		check(d, ARR); // array mode
		bus_write(23'h000000, 8'h90);
		bus_read(23'h000000, d);
		check(d, {16'h0000, MFR}); // maker code
		bus_read(23'h000002, d);
		check(d, {16'h0000, DEV}); // wide index
		word32 = 1'b0;
		bus_read(23'h000001, d);
		check({16'h0000, d[15:0]}, {16'h0000, DEV}); // narrow index
		bus_write(23'h000000, 8'h98);
		bus_read(23'h000000, d);
		check({16'h0000, d[15:0]}, {16'h0000, QRY[15:0]}); // query mode
		word32 = 1'b1;
		bus_write(23'h000000, 8'h70);
		bus_read(23'h012345, d);
		check(d, 32'h80); // any address
		check(last_oe, 32'hff); // low lanes
		bus_write(ba(7'd5), 8'h60);
		bus_write(ba(7'd5), 8'h01);
		expect_status(8'h80); // auto status
		check({30'h0, last_kind}, {30'h0, OP_PROT}); // protect
		check({25'h0, blk}, 32'h5); // block index
		bus_write(23'h000000, 8'h90);
		word32 = 1'b0;
		bus_read(ba(7'd5) | 23'h000002, d);
		check({16'h0000, d[15:0]}, 32'h1); // protected
		bus_read(ba(7'd6) | 23'h000002, d);
		check({16'h0000, d[15:0]}, 32'h0); // unprotected
		word32 = 1'b1;
		bus_write(23'h000000, 8'h20);
		bus_write(ba(7'd5), 8'hd0);
		expect_status(8'ha2); // protected erase
		bus_write(23'h000000, 8'h70);
		expect_status(8'ha2); // sticky
		clear_status();
		vpp_ok = 1'b0;
		bus_write(23'h000000, 8'h20);
		bus_write(ba(7'd1), 8'hd0);
		expect_status(8'ha8); // supply low
		vpp_ok = 1'b1;
		clear_status();
		lat = 8'h40;
		bus_write(23'h000000, 8'h20);
		bus_write(ba(7'd1), 8'hd0);
		@(negedge clk_i);
		ce_b = 1'b0;
		oe_b = 1'b0;
		repeat (3) @(negedge clk_i);
		check(data_oe, 32'h80); // busy lanes
		check({31'h0, data_o[7]}, 32'h0); // busy low
		repeat (80) @(negedge clk_i);
		check({31'h0, data_o[7]}, 32'h0); // held snapshot
		oe_b = 1'b1;
		@(negedge clk_i);
		oe_b = 1'b0;
		repeat (3) @(negedge clk_i);
		check(data_o, 32'h80); // refreshed
		ce_b = 1'b1;
		oe_b = 1'b1;
		lat = 8'hc0;
		bus_write(23'h000000, 8'h20);
		bus_write(ba(7'd1), 8'hd0);
		bus_write(23'h000000, 8'hb0);
		bus_read(23'h000000, d);
		check({31'h0, d[7]}, 32'h0); // not yet paused
		expect_status(8'hc0); // erase suspended
		bus_write(23'h000000, 8'hd0);
		@(negedge clk_i);
		check(32'(n_res), 32'h1); // resume
		check({31'h0, st[6]}, 32'h0); // cleared
		expect_status(8'h80); // completes
		bus_write(ba(7'd2), 8'he8);
		bus_write(ba(7'd2), 8'h01);
		bus_write(ba(7'd2), 8'h11);
		bus_write(ba(7'd2) | 23'h000002, 8'h22);
		bus_write(23'h000000, 8'hd0);
		repeat (3) @(negedge clk_i);
		check({30'h0, last_kind}, {30'h0, OP_PROG}); // program
		check(32'(n_buf), 32'h2); // pairs
		check({9'h000, wta}, {9'h000, ba(7'd2) | 23'h000002}); // pair address
		check(wval, 32'h00000022); // pair data
		bus_write(23'h000000, 8'hb0);
		expect_status(8'h84); // program suspended
		bus_write(23'h000000, 8'hd0);
		check({31'h0, st[2]}, 32'h0); // cleared
		expect_status(8'h80); // completes
		bus_write(ba(7'd2), 8'he8);
		bus_write(ba(7'd2), 8'h08);
		expect_status(8'hb0); // bad count
		clear_status();
		bus_write(ba(7'd2), 8'he8);
		bus_write(ba(7'd2), 8'h00);
		bus_write(ba(7'd2), 8'h33);
		bus_write(23'h000000, 8'hff);
		bus_write(23'h000000, 8'h70);
		expect_status(8'hb0); // bad confirm
		clear_status();
		fail = 1'b1;
		bus_write(23'h000000, 8'h60);
		bus_write(23'h000000, 8'hd0);
		expect_status(8'ha0); // unprotect fail
		fail = 1'b0;
		clear_status();
		bus_write(23'h000000, 8'h60);
		bus_write(23'h000000, 8'hd0);
		expect_status(8'h80); // unprotect all
		na = n_apply;
		bus_write(23'h000000, 8'hff);
		bus_read(23'h000000, d);
		check(d, ARR); // array mode
		check(32'(n_apply - na), 32'h1); // burst reapplied
		bus_write(23'h000000, 8'h90);
		word32 = 1'b0;
		bus_read(ba(7'd5) | 23'h000002, d);
		check({16'h0000, d[15:0]}, 32'h0); // unprotected
		word32 = 1'b1;
		bus_write(23'h00b4b4, 8'h60);
		bus_write(23'h00b4b4, 8'h03);
		bus_read(23'h000000, d);
		check({16'h0000, bsv}, 32'h5a5a); // burst setup
		check(d, ARR); // back to array
		final_report();
	end
endmodule : tb
`default_nettype wire

// ===== hdl/fcs_pkg.sv
package fcs_pkg;

	// ********************************
	// Clock and suspend latency
	// ********************************
	localparam int CLK_MHZ = 50;
	localparam int PROG_SUSP_MAX_US = 10;
	localparam int ERASE_SUSP_MAX_US = 30;
	// Longest times round down; whole microseconds at 50 MHz divide exactly
	localparam logic [10:0] PROG_SUSP_CYC = 11'(PROG_SUSP_MAX_US * CLK_MHZ);
	localparam logic [10:0] ERASE_SUSP_CYC = 11'(ERASE_SUSP_MAX_US * CLK_MHZ);

	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_READ_QUERY = 8'h98;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_BUF_SETUP = 8'he8;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_CFG_SETUP = 8'h60;
	localparam logic [7:0] CMD_CFG_BURST = 8'h03;
	localparam logic [7:0] CMD_CFG_PROTECT = 8'h01;

	// ********************************
	// Address layout
	// ********************************
	localparam int NUM_BLOCKS = 128;
	localparam int BLK_MSB = 23;
	localparam int BLK_LSB = 17;
	localparam int PAGE_LSB = 5;
	localparam int BURST_MSB = 17;
	localparam int BURST_LSB = 2;
	localparam logic [15:0] IDENT_PROT_OFS = 16'h0002;
	localparam logic [21:0] IDENT_MFR_IDX = 22'h000000;
	localparam logic [21:0] IDENT_DEV_IDX = 22'h000001;
	localparam logic [15:0] BUF_MAX_X16 = 16'h000f;
	localparam logic [15:0] BUF_MAX_X32 = 16'h0007;

	// ********************************
	// Output lane masks
	// ********************************
	localparam logic [31:0] LANES_X16 = 32'h0000ffff;
	localparam logic [31:0] LANES_X32 = 32'hffffffff;
	localparam logic [31:0] LANES_STATUS = 32'h000000ff;
	localparam logic [31:0] LANES_BUSY = 32'h00000080;

	// ********************************
	// Enumerations
	// ********************************
	typedef enum logic [1:0] {
		RD_ARRAY = 2'b00,
		RD_IDENT = 2'b01,
		RD_QUERY = 2'b10,
		RD_STATUS = 2'b11
	} fcs_mode_t;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_ERASE = 3'b001,
		SEQ_BUFCNT = 3'b010,
		SEQ_BUFDAT = 3'b011,
		SEQ_BUFCFM = 3'b100,
		SEQ_CFG = 3'b101
	} fcs_seq_t;

	typedef enum logic [2:0] {
		CTL_IDLE = 3'b000,
		CTL_CHK = 3'b001,
		CTL_EVAL = 3'b010,
		CTL_RUN = 3'b011,
		CTL_SREQ = 3'b100,
		CTL_SUSP = 3'b101
	} fcs_ctl_t;

	typedef enum logic [1:0] {
		OP_ERASE = 2'b00,
		OP_PROG = 2'b01,
		OP_PROT = 2'b10,
		OP_UNPROT = 2'b11
	} fcs_op_t;

endpackage : fcs_pkg

// ===== hdl/fcs_prot_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_prot_mem (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [6:0] rd_addr_i,
	input wire logic wr_i,
	input wire logic [6:0] wr_addr_i,
	input wire logic clr_all_i,
	output logic rd_data_o
);
	import fcs_pkg::*;

	typedef struct packed {
		logic [NUM_BLOCKS-1:0] bits;
		logic rd;
	} fcs_mem_state_t;

	fcs_mem_state_t s;
	fcs_mem_state_t n;
	logic [NUM_BLOCKS-1:0] set_mask;

	// ********************************
	// One protection bit per block
	// ********************************
	// Bits are flops, so they do not survive reset as non-volatile cells would
	genvar g;
	generate
		for (g = 0; g < NUM_BLOCKS; g++) begin : g_set
			assign set_mask[g] = wr_i && (wr_addr_i == 7'(g));
		end
	endgenerate

	always_comb begin
		n = s;
		n.bits = clr_all_i ? '0 : (s.bits | set_mask);
		n.rd = s.bits[rd_addr_i];
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rd_data_o = s.rd;
endmodule : fcs_prot_mem
`default_nettype wire

// ===== hdl/fcs_susp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_susp_timer (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic erase_i,
	output logic tmo_o
);
	import fcs_pkg::*;

	typedef struct packed {
		logic [10:0] cnt;
	} fcs_tmr_state_t;

	fcs_tmr_state_t s;
	fcs_tmr_state_t n;
	logic [10:0] lim;

	// ********************************
	// Suspend latency watchdog
	// ********************************
	// Fires two cycles early so the pause lands within the limit, not after it
	always_comb begin
		n = s;
		lim = erase_i ? ERASE_SUSP_CYC : PROG_SUSP_CYC;
		n.cnt = run_i ? 11'(s.cnt + 11'h001) : 11'h000;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tmo_o = run_i && (s.cnt >= 11'(lim - 11'h002));
endmodule : fcs_susp_timer
`default_nettype wire

// ===== hdl/fcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_top #(
	// Arbitrary neutral identification values
	parameter logic [15:0] MFR_ID = 16'h00a5,
	parameter logic [15:0] DEV_ID = 16'h5a3c
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_b_i,
	input wire logic oe_b_i,
	input wire logic we_b_i,
	input wire logic [23:1] addr_i,
	input wire logic [31:0] data_i,
	input wire logic word32_i,
	input wire logic vpp_ok_i,
	input wire logic [31:0] array_data_i,
	input wire logic [31:0] query_data_i,
	input wire logic core_done_i,
	input wire logic core_fail_i,
	input wire logic core_pause_i,
	output logic [31:0] data_o,
	output logic [31:0] data_oe_o,
	output logic [7:0] operation_status_o,
	output logic [15:0] burst_setup_value_o,
	output logic burst_apply_o,
	output logic op_start_o,
	output fcs_pkg::fcs_op_t op_kind_o,
	output logic [6:0] block_base_addr_o,
	output logic buf_wr_o,
	output logic [23:1] write_target_addr_o,
	output logic [31:0] write_value_o,
	output logic suspend_o,
	output logic resume_o
);
	import fcs_pkg::*;

	typedef struct packed {
		fcs_mode_t mode;
		fcs_seq_t seq;
		fcs_ctl_t ctl;
		fcs_op_t op;
		logic [6:0] blk;
		logic [18:0] page;
		logic [3:0] left;
		logic first;
		logic e5;
		logic e4;
		logic e3;
		logic e1;
		logic esusp;
		logic psusp;
		logic we_q;
		logic rd_q;
		logic [31:0] dout;
		logic [15:0] burst;
		logic bapply;
		logic start;
		logic bwr;
		logic resume;
		logic [23:1] baddr;
		logic [31:0] bdata;
		logic [10:0] swait;
	} fcs_state_t;

	fcs_state_t s;
	fcs_state_t n;
	logic wr;
	logic rd;
	logic rd_start;
	logic ready;
	logic [7:0] cmd;
	logic [6:0] blk_in;
	logic [7:0] status;
	logic clr;
	logic set_seq;
	logic set_op;
	logic set_e3;
	logic set_e1;
	logic prot_bit;
	logic tmo;
	logic mem_wr;
	logic mem_clr;
	logic [6:0] mem_addr;
	logic [21:0] id_idx;
	logic [15:0] id_ofs;
	logic [15:0] buf_max;

	// ********************************
	// Bus sampling
	// ********************************
	// Write taken on the rising edge of write enable with chip enable low
	assign wr = !s.we_q && we_b_i && !ce_b_i;
	assign rd = !ce_b_i && !oe_b_i && we_b_i;
	assign rd_start = rd && !s.rd_q;
	assign cmd = data_i[7:0];
	assign blk_in = addr_i[BLK_MSB:BLK_LSB];
	assign ready = (s.ctl == CTL_IDLE) || (s.ctl == CTL_SUSP);
	assign status = {ready, s.esusp, s.e5, s.e4, s.e3, s.psusp, s.e1, 1'b0};
	assign buf_max = word32_i ? BUF_MAX_X32 : BUF_MAX_X16;
	assign id_idx = word32_i ? {1'b0, addr_i[22:2]} : addr_i[22:1];
	assign id_ofs = word32_i ? {1'b0, addr_i[16:2]} : addr_i[16:1];
	assign mem_addr = (s.ctl == CTL_CHK || s.ctl == CTL_EVAL) ? s.blk : blk_in;
	assign mem_wr = (s.ctl == CTL_RUN || s.ctl == CTL_SREQ) && core_done_i &&
		!core_fail_i && (s.op == OP_PROT);
	assign mem_clr = (s.ctl == CTL_RUN || s.ctl == CTL_SREQ) && core_done_i &&
		!core_fail_i && (s.op == OP_UNPROT);

	fcs_prot_mem u_prot (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.rd_addr_i(mem_addr),
		.wr_i(mem_wr),
		.wr_addr_i(s.blk),
		.clr_all_i(mem_clr),
		.rd_data_o(prot_bit)
	);

	fcs_susp_timer u_tmr (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.run_i(s.ctl == CTL_SREQ),
		.erase_i(s.op == OP_ERASE),
		.tmo_o(tmo)
	);

	// ********************************
	// Command decoder and controller
	// ********************************
	always_comb begin
		n = s;
		clr = 1'b0;
		set_seq = 1'b0;
		set_op = 1'b0;
		set_e3 = 1'b0;
		set_e1 = 1'b0;
		n.we_q = we_b_i;
		n.rd_q = rd;
		n.start = 1'b0;
		n.bwr = 1'b0;
		n.resume = 1'b0;
		n.swait = (s.ctl == CTL_SREQ) ? 11'(s.swait + 11'h001) : 11'h000;
		if (wr) begin
			unique case (s.seq)
				SEQ_IDLE: begin
					if (cmd == CMD_READ_STATUS) begin
						n.mode = RD_STATUS;
					end
					if (ready) begin
						if (cmd == CMD_READ_ARRAY) n.mode = RD_ARRAY;
						if (cmd == CMD_READ_IDENT) n.mode = RD_IDENT;
						if (cmd == CMD_READ_QUERY) n.mode = RD_QUERY;
						if (cmd == CMD_CLEAR_STATUS) clr = 1'b1;
						if (cmd == CMD_CONFIRM && s.ctl == CTL_SUSP) begin
							n.ctl = CTL_RUN;
							n.esusp = 1'b0;
							n.psusp = 1'b0;
							n.resume = 1'b1;
							n.mode = RD_STATUS;
						end
					end
					// New operations only with the controller fully idle
					if (s.ctl == CTL_IDLE) begin
						if (cmd == CMD_ERASE_SETUP) n.seq = SEQ_ERASE;
						if (cmd == CMD_BUF_SETUP) begin
							n.seq = SEQ_BUFCNT;
							n.blk = blk_in;
							n.mode = RD_STATUS;
						end
						if (cmd == CMD_CFG_SETUP) n.seq = SEQ_CFG;
					end
					if (cmd == CMD_SUSPEND && s.ctl == CTL_RUN &&
						(s.op == OP_ERASE || s.op == OP_PROG)) begin
						n.ctl = CTL_SREQ;
						n.mode = RD_STATUS;
					end
				end
				SEQ_ERASE: begin
					n.seq = SEQ_IDLE;
					n.mode = RD_STATUS;
					if (cmd == CMD_CONFIRM) begin
						n.op = OP_ERASE;
						n.blk = blk_in;
						n.ctl = CTL_CHK;
					end else begin
						set_seq = 1'b1;
					end
				end
				SEQ_BUFCNT: begin
					// count must fit and stay in block
					if (blk_in == s.blk && data_i[15:0] <= buf_max) begin
						n.left = data_i[3:0];
						n.first = 1'b1;
						n.seq = SEQ_BUFDAT;
					end else begin
						set_seq = 1'b1;
						n.seq = SEQ_IDLE;
					end
				end
				SEQ_BUFDAT: begin
					if ((s.first && blk_in == s.blk) ||
						(!s.first && addr_i[23:PAGE_LSB] == s.page)) begin
						n.bwr = 1'b1;
						n.baddr = addr_i;
						n.bdata = data_i;
						n.page = addr_i[23:PAGE_LSB];
						n.first = 1'b0;
						n.left = 4'(s.left - 4'h1);
						if (s.left == 4'h0) n.seq = SEQ_BUFCFM;
					end else begin
						set_seq = 1'b1;
						n.seq = SEQ_IDLE;
					end
				end
				SEQ_BUFCFM: begin
					n.seq = SEQ_IDLE;
					if (cmd == CMD_CONFIRM) begin
						n.op = OP_PROG;
						n.ctl = CTL_CHK;
					end else begin
						set_seq = 1'b1;
					end
				end
				SEQ_CFG: begin
					n.seq = SEQ_IDLE;
					if (cmd == CMD_CFG_BURST) begin
						n.burst = addr_i[BURST_MSB:BURST_LSB];
						n.mode = RD_ARRAY;
					end else if (cmd == CMD_CFG_PROTECT) begin
						n.op = OP_PROT;
						n.blk = blk_in;
						n.ctl = CTL_CHK;
						n.mode = RD_STATUS;
					end else if (cmd == CMD_CONFIRM) begin
						n.op = OP_UNPROT;
						n.ctl = CTL_CHK;
						n.mode = RD_STATUS;
					end else begin
						set_seq = 1'b1;
					end
				end
				default: n.seq = SEQ_IDLE;
			endcase
		end
		unique case (s.ctl)
			CTL_CHK: n.ctl = CTL_EVAL;
			CTL_EVAL: begin
				if (!vpp_ok_i) begin
					set_e3 = 1'b1;
					set_op = 1'b1;
					n.ctl = CTL_IDLE;
				end else if (prot_bit && (s.op == OP_ERASE || s.op == OP_PROG)) begin
					set_e1 = 1'b1;
					set_op = 1'b1;
					n.ctl = CTL_IDLE;
				end else begin
					n.start = 1'b1;
					n.ctl = CTL_RUN;
				end
			end
			CTL_RUN, CTL_SREQ: begin
				// Completion beats a pending suspend
				if (core_done_i) begin
					n.ctl = CTL_IDLE;
					set_op = core_fail_i;
				end else if (s.ctl == CTL_SREQ && (core_pause_i || tmo)) begin
					n.ctl = CTL_SUSP;
					n.esusp = (s.op == OP_ERASE);
					n.psusp = (s.op == OP_PROG);
				end
			end
			default: begin
			end
		endcase
		n.e5 = (s.e5 && !clr) || set_seq ||
			(set_op && (s.op == OP_ERASE || s.op == OP_UNPROT));
		n.e4 = (s.e4 && !clr) || set_seq ||
			(set_op && (s.op == OP_PROG || s.op == OP_PROT));
		n.e3 = (s.e3 && !clr) || set_e3;
		n.e1 = (s.e1 && !clr) || set_e1;
		n.bapply = (n.mode == RD_ARRAY) && (s.mode != RD_ARRAY);
		unique case (s.mode)
			RD_ARRAY: n.dout = array_data_i;
			RD_QUERY: n.dout = query_data_i;
			RD_IDENT: begin
				if (id_idx == IDENT_MFR_IDX) n.dout = {16'h0000, MFR_ID};
				else if (id_idx == IDENT_DEV_IDX) n.dout = {16'h0000, DEV_ID};
				// protect bit at base plus 2
				else if (id_ofs == IDENT_PROT_OFS) n.dout = {31'h00000000, prot_bit};
				else n.dout = 32'h00000000;
			end
			RD_STATUS: begin
				if (rd_start) n.dout = {24'h000000, status};
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
			// Write strobe idles high, so no false edge at release
			s.we_q <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ********************************
	// Outputs
	// ********************************
	always_comb begin
		data_oe_o = 32'h00000000;
		if (rd) begin
			if (s.mode == RD_STATUS) begin
				// busy snapshot drives bit 7 only
				data_oe_o = s.dout[7] ? LANES_STATUS : LANES_BUSY;
			end else begin
				data_oe_o = word32_i ? LANES_X32 : LANES_X16;
			end
		end
	end

	assign data_o = s.dout;
	assign operation_status_o = status;
	assign burst_setup_value_o = s.burst;
	assign burst_apply_o = s.bapply;
	assign op_start_o = s.start;
	assign op_kind_o = s.op;
	assign block_base_addr_o = s.blk;
	assign buf_wr_o = s.bwr;
	assign write_target_addr_o = s.baddr;
	assign write_value_o = s.bdata;
	assign suspend_o = (s.ctl == CTL_SREQ);
	assign resume_o = s.resume;

	// ********************************
	// Checks
	// ********************************
	localparam int P_SUSP_BOUND = PROG_SUSP_CYC;
	localparam int E_SUSP_BOUND = ERASE_SUSP_CYC;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_busy_bit_low: assert property (s.ctl == CTL_RUN |-> !operation_status_o[7])
		else $error("ready bit high while running");
	chk_error_sticky: assert property (s.e5 && !clr |=> s.e5)
		else $error("erase error dropped without clear");
	chk_prog_susp_time: assert property ($rose(s.ctl == CTL_SREQ) && s.op == OP_PROG |->
		##[1:P_SUSP_BOUND] s.ctl != CTL_SREQ)
		else $error("program suspend too slow");
	// Erase bound is too long for a delay range, so a cycle counter carries it
	chk_erase_susp_time: assert property (s.ctl == CTL_SREQ && s.op == OP_ERASE |->
		s.swait < E_SUSP_BOUND)
		else $error("erase suspend too slow");
	chk_start_status: assert property (op_start_o |-> s.mode == RD_STATUS)
		else $error("operation started outside status mode");
	chk_busy_lanes: assert property (rd && s.mode == RD_STATUS && !data_o[7] |->
		data_oe_o == LANES_BUSY)
		else $error("busy status drives extra lanes");
	chk_seq_abort: assert property (wr && s.seq == SEQ_BUFCFM && cmd != CMD_CONFIRM |=>
		s.e5 && s.e4 && s.ctl == CTL_IDLE && !op_start_o)
		else $error("broken sequence not aborted");
	chk_vpp_error: assert property (s.ctl == CTL_EVAL && !vpp_ok_i |=>
		s.e3 && !op_start_o ##1 !op_start_o)
		else $error("low supply did not abort");
	chk_status_hold: assert property (s.mode == RD_STATUS && n.mode == RD_STATUS &&
		rd && s.rd_q |=> $stable(data_o))
		else $error("status changed within one read");
	chk_suspend_flags: assert property (s.ctl == CTL_SUSP |->
		operation_status_o[7] && (operation_status_o[6] != operation_status_o[2]))
		else $error("suspend flags wrong");

	cov_erase_done: cover property (s.op == OP_ERASE && s.ctl == CTL_RUN ##1 s.ctl == CTL_IDLE);
	cov_prog_susp: cover property (s.op == OP_PROG && s.ctl == CTL_SUSP);
	cov_ident_prot: cover property (s.mode == RD_IDENT && rd && prot_bit);
	cov_burst_apply: cover property (burst_apply_o);
endmodule : fcs_top
`default_nettype wire
